// ==== panel_key_pkg.sv ====
// shared constants and carrier types of the front-panel key and reset control
// assumes one 20 MHz clock and a synchronous active-high reset
package panel_key_pkg;
	localparam int CLK_HZ        = 20_000_000;
	localparam int RESET_HOLD_MS = 1000;
	localparam int MODE_HOLD_MS  = 2000;
	localparam int DEBOUNCE_MS   = 10;
	localparam int BLINK_HALF_MS = 250;
	localparam int RESET_HOLD_CYC = (CLK_HZ / 1000) * RESET_HOLD_MS;
	localparam int MODE_HOLD_CYC  = (CLK_HZ / 1000) * MODE_HOLD_MS;
	localparam int DEBOUNCE_CYC   = (CLK_HZ / 1000) * DEBOUNCE_MS;
	localparam int BLINK_HALF_CYC = (CLK_HZ / 1000) * BLINK_HALF_MS;

	localparam int NUM_DIGITS = 6;
	localparam int NUM_KEYS   = 12;
	localparam int VALUE_W    = 20;
	localparam int TIMER_W    = 26;
	localparam int DEB_W      = 20;
	localparam int ADDR_W     = 4;
	localparam int DATA_W     = 16;

	// key vector: [5:0] increment digits 1..6, [11:6] decrement digits 1..6
	localparam int KEY_INC1 = 0;
	localparam int KEY_INC3 = 2;
	localparam int KEY_INC6 = 5;
	localparam int KEY_DEC1 = 6;
	localparam int KEY_DEC3 = 8;
	localparam int KEY_DEC6 = 11;

	localparam logic [ADDR_W-1:0] REG_CTRL   = 4'h0;
	localparam logic [ADDR_W-1:0] REG_STATUS = 4'h1;
	localparam logic [ADDR_W-1:0] REG_KEYS   = 4'h2;
	localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0000;
	localparam int CTRL_CFG_LSB   = 0;
	localparam int CTRL_IND_LSB   = 3;
	localparam int CTRL_ALT_BIT   = 5;
	localparam int CTRL_INDEP_BIT = 6;
	localparam int CTRL_LIMIT_BIT = 7;
	localparam int STAT_SETUP_BIT = 0;
	localparam int STAT_GEST_LSB  = 1;
	localparam int STAT_RST_BIT   = 5;
	localparam int STAT_HOLDA_BIT = 6;
	localparam int STAT_HOLDB_BIT = 7;

	typedef enum logic [2:0] {
		CFG_PRESET = 3'h0,
		CFG_TOTAL  = 3'h1,
		CFG_BATCH  = 3'h2,
		CFG_DUAL   = 3'h3,
		CFG_TWIN   = 3'h4,
		CFG_TACHO  = 3'h5
	} cfg_type;

	typedef enum logic [1:0] {
		IND_BAR = 2'h0,
		IND_OFF = 2'h1,
		IND_LIT = 2'h2
	} ind_type;

	typedef enum logic [3:0] {
		G_IDLE  = 4'h1,
		G_RST   = 4'h2,
		G_MODE  = 4'h4,
		G_LATCH = 4'h8
	} gest_type;

	typedef struct packed {
		logic clrPresentA;
		logic clrPresentB;
		logic clrTotal;
		logic clrBatch;
		logic clrDual;
		logic clrOut1;
		logic clrOut2;
	} clear_type;

	typedef struct packed {
		logic             meta;
		logic             sync;
		logic             stable;
		logic [DEB_W-1:0] cnt;
	} debounce_state_type;

	typedef struct packed {
		gest_type            gest;
		logic [TIMER_W-1:0]  timer;
		logic                modeDec;
		logic                firedReset;
		logic [NUM_KEYS-1:0] keyPrev;
		logic [NUM_KEYS-1:0] keyUsed;
		logic [TIMER_W-1:0]  blinkCnt;
		logic                blinkOn;
		logic                setupMode;
		logic [DATA_W-1:0]   ctrl;
		logic [DATA_W-1:0]   rdData;
		clear_type           clr;
		logic                enterSetup;
		logic [NUM_DIGITS-1:0] incEdit;
		logic [NUM_DIGITS-1:0] decEdit;
		logic                holdA;
		logic                holdB;
		logic [NUM_KEYS-1:0] leds;
		logic                resetLamp;
		logic                holdLamp;
		logic                totalLamp;
		logic                batchLamp;
	} panel_state_type;
endpackage : panel_key_pkg

// ==== debounce_sync.sv ====
// two-stage synchroniser followed by a stability counter for one panel input
// assumes the raw input is asynchronous to mclk
module debounce_sync
	import panel_key_pkg::*;
#(
	parameter int STABLE_CYC = DEBOUNCE_CYC
) (
	input  wire logic mclk,
	input  wire logic rst,
	input  wire logic rawPin,
	output logic      clean
);
	debounce_state_type s_r;
	debounce_state_type s_nxt;

	always_comb begin
		s_nxt = s_r;
		s_nxt.meta = rawPin;
		s_nxt.sync = s_r.meta;
		// the counter restarts on every bounce so only a steady level is accepted
		if (s_r.sync == s_r.stable) begin
			s_nxt.cnt = '0;
		end else if (s_r.cnt == DEB_W'(STABLE_CYC - 1)) begin
			s_nxt.cnt = '0;
			s_nxt.stable = s_r.sync;
		end else begin
			s_nxt.cnt = s_r.cnt + DEB_W'(1);
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign clean = s_r.stable;
endmodule : debounce_sync

// ==== panel_key_reset_control.sv ====
// front-panel key gestures, indicator drive and panel reset dispatch
// assumes the counting core shares mclk and that keys and reset input are raw pins
//
// Summary of operation
// - panel reset fires only after digit6 up and down held together one second
// - releasing either reset key before one second cancels with no effect
// - all status indicator segments blink while both reset keys are held, until the reset fires
// - a lone digit6 key press edits that digit instead of resetting
// - digit1+digit3 up pair or down pair held two seconds enters setting mode
// - releasing the mode pair early abandons the mode change
// - while the mode pair is held its digit1 and digit3 indicators blink, until setting mode is entered
// - six increment and six decrement keys, one pair per digit, right to left
// - counter use in bar mode shows present over set value, 0 to 100 percent
// - tachometer limit mode shows measurement over comparison value, bar blank otherwise
// - indicator mode all off or all lit drives every segment uniformly
// - any key press outside a reset or mode pair hold blanks the bar and lights the pressed keys instead
// - in setting mode, with no key pressed, only keys able to change the parameter are lit
// - reset lamp lit while reset input one is on or a panel reset runs
// - reset lamp and hold display work only in counting configurations
// - total lamp with total count shown, batch lamp with batch count shown
// - preset configs clear present value and outputs, plus total if shown
// - batch config clears present and second output, all if batch shown
// - dual config clears both present values, dual count and all outputs
// - twin config clears only the displayed channel and its matching output
// - tachometer config freezes measurement and outputs while hold applies
// - independent two-input tachometer holds only the displayed channel
module panel_key_reset_control
	import panel_key_pkg::*;
#(
	parameter int RESET_HOLD = RESET_HOLD_CYC,
	parameter int MODE_HOLD  = MODE_HOLD_CYC,
	parameter int DEBOUNCE   = DEBOUNCE_CYC,
	parameter int BLINK_HALF = BLINK_HALF_CYC
) (
	input  wire logic                  mclk,
	input  wire logic                  rst,
	input  wire logic [NUM_DIGITS-1:0] keyIncPin,
	input  wire logic [NUM_DIGITS-1:0] keyDecPin,
	input  wire logic                  resetInputPin,
	input  wire logic [ADDR_W-1:0]     regAddr,
	input  wire logic [DATA_W-1:0]     regWrData,
	input  wire logic                  regWrStb,
	input  wire logic                  regRdStb,
	output logic      [DATA_W-1:0]     regRdData,
	input  wire logic [VALUE_W-1:0]    valueNow,
	input  wire logic [VALUE_W-1:0]    valueRef,
	input  wire logic [NUM_KEYS-1:0]   settableKeys,
	input  wire logic                  counterHoldShown,
	output logic      [NUM_KEYS-1:0]   keyLeds,
	output logic                       resetLamp,
	output logic                       holdLamp,
	output logic                       totalLamp,
	output logic                       batchLamp,
	output logic      [NUM_DIGITS-1:0] digitIncPulse,
	output logic      [NUM_DIGITS-1:0] digitDecPulse,
	output logic                       setupEnterPulse,
	output clear_type                  panelClear,
	output logic                       tachoHoldA,
	output logic                       tachoHoldB
);
	panel_state_type s_r;
	panel_state_type s_nxt;

	logic [NUM_KEYS:0] rawIn;
	logic [NUM_KEYS:0] cleanIn;
	logic [NUM_KEYS-1:0] keys;
	logic              resetIn1;

	assign rawIn = {resetInputPin, keyDecPin, keyIncPin};

	genvar gi;
	generate
		for (gi = 0; gi <= NUM_KEYS; gi++) begin : g_deb
			debounce_sync #(
				.STABLE_CYC(DEBOUNCE)
			) u_deb (
				.mclk  (mclk),
				.rst   (rst),
				.rawPin(rawIn[gi]),
				.clean (cleanIn[gi])
			);
		end
	endgenerate

	assign keys     = cleanIn[NUM_KEYS-1:0];
	assign resetIn1 = cleanIn[NUM_KEYS];

	// bar of twelve segments; segment i lights once now/ref reaches (i+1)/12
	function automatic logic [NUM_KEYS-1:0] barFill(
		input logic [VALUE_W-1:0] now,
		input logic [VALUE_W-1:0] fullScale
	);
		logic [NUM_KEYS-1:0] bar;
		logic [VALUE_W+4:0]  scaledNow;
		logic [VALUE_W+4:0]  scaledRef;
		bar = '0;
		scaledNow = (VALUE_W + 5)'(now) * (VALUE_W + 5)'(NUM_KEYS);
		for (int i = 0; i < NUM_KEYS; i++) begin
			scaledRef = (VALUE_W + 5)'(fullScale) * (VALUE_W + 5)'(i + 1);
			bar[i] = (fullScale == '0) ? (now != '0) : (scaledNow >= scaledRef);
		end
		return bar;
	endfunction : barFill

	// what a panel reset clears, by configuration and by what is displayed
	function automatic clear_type resetDispatch(
		input cfg_type cfg,
		input logic    alt
	);
		clear_type c;
		c = '0;
		case (cfg)
			CFG_PRESET, CFG_TOTAL: begin
				c.clrPresentA = 1'b1;
				c.clrOut1     = 1'b1;
				c.clrOut2     = 1'b1;
				c.clrTotal    = (cfg == CFG_TOTAL) && alt;
			end
			CFG_BATCH: begin
				c.clrPresentA = 1'b1;
				c.clrOut2     = 1'b1;
				c.clrBatch    = alt;
				c.clrOut1     = alt;
			end
			CFG_DUAL: begin
				c = '{clrPresentA: 1'b1, clrPresentB: 1'b1, clrTotal: 1'b0,
				      clrBatch: 1'b0, clrDual: 1'b1, clrOut1: 1'b1,
				      clrOut2: 1'b1};
			end
			CFG_TWIN: begin
				c.clrPresentA = !alt;
				c.clrOut1     = !alt;
				c.clrPresentB = alt;
				c.clrOut2     = alt;
			end
			default: begin
				c = '0;
			end
		endcase
		return c;
	endfunction : resetDispatch

	always_comb begin
		logic                rstPair;
		logic                modeIncPair;
		logic                modeDecPair;
		logic                heldPair;
		logic [NUM_KEYS-1:0] mark;
		logic [NUM_KEYS-1:0] released;
		logic [NUM_KEYS-1:0] bar;
		logic [NUM_KEYS-1:0] blinkMask;
		cfg_type             cfg;
		ind_type             ind;
		logic                alt;
		logic                indep;
		logic                tacho;
		logic                resetRunning;
		rstPair     = keys[KEY_INC6] && keys[KEY_DEC6];
		modeIncPair = keys[KEY_INC1] && keys[KEY_INC3];
		modeDecPair = keys[KEY_DEC1] && keys[KEY_DEC3];
		heldPair    = 1'b0;
		mark        = '0;
		released    = '0;
		bar         = '0;
		blinkMask   = '0;
		resetRunning = 1'b0;
		cfg   = cfg_type'(s_r.ctrl[CTRL_CFG_LSB +: 3]);
		ind   = ind_type'(s_r.ctrl[CTRL_IND_LSB +: 2]);
		alt   = s_r.ctrl[CTRL_ALT_BIT];
		indep = s_r.ctrl[CTRL_INDEP_BIT];
		tacho = (cfg == CFG_TACHO);

		s_nxt            = s_r;
		s_nxt.clr        = '0;
		s_nxt.enterSetup = 1'b0;
		s_nxt.incEdit    = '0;
		s_nxt.decEdit    = '0;
		s_nxt.keyPrev    = keys;

		if (s_r.blinkCnt == TIMER_W'(BLINK_HALF - 1)) begin
			s_nxt.blinkCnt = '0;
			s_nxt.blinkOn  = !s_r.blinkOn;
		end else begin
			s_nxt.blinkCnt = s_r.blinkCnt + TIMER_W'(1);
		end

		// bus write first so that a gesture in the same cycle wins over a clear
		if (regWrStb) begin
			if (regAddr == REG_CTRL) begin
				s_nxt.ctrl = regWrData;
			end else if (regAddr == REG_STATUS && regWrData[STAT_SETUP_BIT]) begin
				s_nxt.setupMode = 1'b0;
			end
		end

		case (s_r.gest)
			G_IDLE: begin
				s_nxt.timer      = '0;
				s_nxt.firedReset = 1'b0;
				if (rstPair) begin
					s_nxt.gest = G_RST;
				end else if (modeIncPair || modeDecPair) begin
					s_nxt.gest    = G_MODE;
					s_nxt.modeDec = !modeIncPair;
				end
			end
			G_RST: begin
				if (!rstPair) begin
					s_nxt.gest  = G_IDLE;
					s_nxt.timer = '0;
				end else if (s_r.timer == TIMER_W'(RESET_HOLD - 1)) begin
					s_nxt.gest       = G_LATCH;
					s_nxt.firedReset = 1'b1;
					if (!tacho) begin
						s_nxt.clr = resetDispatch(cfg, alt);
					end
				end else begin
					s_nxt.timer = s_r.timer + TIMER_W'(1);
				end
			end
			G_MODE: begin
				heldPair = s_r.modeDec ? modeDecPair : modeIncPair;
				if (!heldPair) begin
					s_nxt.gest  = G_IDLE;
					s_nxt.timer = '0;
				end else if (s_r.timer == TIMER_W'(MODE_HOLD - 1)) begin
					s_nxt.gest       = G_LATCH;
					s_nxt.enterSetup = 1'b1;
					s_nxt.setupMode  = 1'b1;
				end else begin
					s_nxt.timer = s_r.timer + TIMER_W'(1);
				end
			end
			G_LATCH: begin
				// wait for the pair to let go so a long hold fires only once
				heldPair = s_r.firedReset ? rstPair
				         : (s_r.modeDec ? modeDecPair : modeIncPair);
				if (!heldPair) begin
					s_nxt.gest = G_IDLE;
				end
			end
			default: begin
				s_nxt.gest = G_IDLE;
			end
		endcase

		// keys that joined a gesture give no digit edit on release
		if (rstPair) begin
			mark[KEY_INC6] = 1'b1;
			mark[KEY_DEC6] = 1'b1;
		end
		if (modeIncPair) begin
			mark[KEY_INC1] = 1'b1;
			mark[KEY_INC3] = 1'b1;
		end
		if (modeDecPair) begin
			mark[KEY_DEC1] = 1'b1;
			mark[KEY_DEC3] = 1'b1;
		end
		released       = s_r.keyPrev & ~keys;
		s_nxt.keyUsed  = (s_r.keyUsed | mark) & keys;
		s_nxt.incEdit  = released[NUM_DIGITS-1:0] & ~s_r.keyUsed[NUM_DIGITS-1:0];
		s_nxt.decEdit  = released[NUM_KEYS-1:NUM_DIGITS]
		               & ~s_r.keyUsed[NUM_KEYS-1:NUM_DIGITS];

		// tachometer hold lasts while the reset pair stays held after firing
		resetRunning = (s_nxt.gest == G_LATCH) && s_nxt.firedReset;
		s_nxt.holdA  = tacho && resetRunning && (!indep || !alt);
		s_nxt.holdB  = tacho && resetRunning && (!indep || alt);

		// indicator priority: gestures, then key presses, then mode display
		if (tacho) begin
			bar = s_r.ctrl[CTRL_LIMIT_BIT] ? barFill(valueNow, valueRef) : '0;
		end else begin
			bar = barFill(valueNow, valueRef);
		end
		blinkMask[KEY_INC1] = !s_r.modeDec;
		blinkMask[KEY_INC3] = !s_r.modeDec;
		blinkMask[KEY_DEC1] = s_r.modeDec;
		blinkMask[KEY_DEC3] = s_r.modeDec;
		if (s_r.gest == G_RST) begin
			s_nxt.leds = {NUM_KEYS{s_r.blinkOn}};
		end else if (s_r.gest == G_MODE) begin
			s_nxt.leds = s_r.blinkOn ? blinkMask : '0;
		end else if (keys != '0) begin
			s_nxt.leds = keys;
		end else if (s_r.setupMode) begin
			s_nxt.leds = settableKeys;
		end else begin
			case (ind)
				IND_OFF: s_nxt.leds = '0;
				IND_LIT: s_nxt.leds = '1;
				default: s_nxt.leds = bar;
			endcase
		end

		s_nxt.resetLamp = !tacho && (resetIn1 || (s_r.gest == G_LATCH && s_r.firedReset)
		                || s_nxt.clr != '0);
		s_nxt.holdLamp  = !tacho && counterHoldShown;
		s_nxt.totalLamp = (cfg == CFG_TOTAL) && alt;
		s_nxt.batchLamp = (cfg == CFG_BATCH) && alt;

		// read data stands only in the cycle after the strobe
		s_nxt.rdData = '0;
		if (regRdStb) begin
			case (regAddr)
				REG_CTRL: s_nxt.rdData = s_r.ctrl;
				REG_STATUS: begin
					s_nxt.rdData[STAT_SETUP_BIT]         = s_r.setupMode;
					s_nxt.rdData[STAT_GEST_LSB +: 4]     = s_r.gest;
					s_nxt.rdData[STAT_RST_BIT]           = s_r.resetLamp;
					s_nxt.rdData[STAT_HOLDA_BIT]         = s_r.holdA;
					s_nxt.rdData[STAT_HOLDB_BIT]         = s_r.holdB;
				end
				REG_KEYS: s_nxt.rdData[NUM_KEYS-1:0] = keys;
				default: s_nxt.rdData = '0;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			s_r      <= '0;
			s_r.gest <= G_IDLE;
			s_r.ctrl <= CTRL_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign regRdData       = s_r.rdData;
	assign keyLeds         = s_r.leds;
	assign resetLamp       = s_r.resetLamp;
	assign holdLamp        = s_r.holdLamp;
	assign totalLamp       = s_r.totalLamp;
	assign batchLamp       = s_r.batchLamp;
	assign digitIncPulse   = s_r.incEdit;
	assign digitDecPulse   = s_r.decEdit;
	assign setupEnterPulse = s_r.enterSetup;
	assign panelClear      = s_r.clr;
	assign tachoHoldA      = s_r.holdA;
	assign tachoHoldB      = s_r.holdB;
endmodule : panel_key_reset_control

// ==== panel_key_reset_control_assertions.sv ====
// port-level assertions for the panel key and reset control
// assumes raw key pins may bounce a few cycles before settling
module panel_key_checker
	import panel_key_pkg::*;
#(
	parameter int RESET_HOLD = 40,
	parameter int MODE_HOLD  = 80
) (
	input wire logic                  mclk,
	input wire logic                  rst,
	input wire logic [NUM_DIGITS-1:0] keyIncPin,
	input wire logic [NUM_DIGITS-1:0] keyDecPin,
	input wire logic                  regRdStb,
	input wire logic [DATA_W-1:0]     regRdData,
	input wire logic [NUM_DIGITS-1:0] digitIncPulse,
	input wire logic [NUM_DIGITS-1:0] digitDecPulse,
	input wire logic                  setupEnterPulse,
	input wire clear_type             panelClear,
	input wire logic                  tachoHoldA,
	input wire logic                  tachoHoldB
);
	timeunit 1ns;
	timeprecision 1ns;
	logic rawPair;
	logic rawMode;
	int   pairCnt_r;
	int   modeCnt_r;
	assign rawPair = keyIncPin[5] && keyDecPin[5];
	assign rawMode = (keyIncPin[0] && keyIncPin[2]) || (keyDecPin[0] && keyDecPin[2]);
	// saturating raw hold counters; any bounce restarts them, as the debouncer would
	always_ff @(posedge mclk) begin
		pairCnt_r <= (rst || !rawPair) ? 0 : (pairCnt_r < MODE_HOLD ? pairCnt_r + 1 : pairCnt_r);
		modeCnt_r <= (rst || !rawMode) ? 0 : (modeCnt_r < MODE_HOLD ? modeCnt_r + 1 : modeCnt_r);
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	sequence pairOff8;
		!rawPair [*8];
	endsequence
	sequence pairOn8;
		rawPair [*8];
	endsequence
	a_rd_quiet: assert property (!regRdStb |=> regRdData == '0)
		else $error("read data outside its slot");
	a_clear_pulse: assert property (|panelClear |=> panelClear == '0)
		else $error("panel clear longer than one cycle");
	a_clear_after_hold: assert property (|panelClear |-> pairCnt_r >= RESET_HOLD)
		else $error("panel clear before full hold");
	a_setup_after_hold: assert property (setupEnterPulse |-> modeCnt_r >= MODE_HOLD)
		else $error("setup entry before full hold");
	a_setup_pulse: assert property (setupEnterPulse |=> !setupEnterPulse)
		else $error("setup entry pulse too long");
	a_hold_start: assert property ($rose(tachoHoldA || tachoHoldB) |-> pairCnt_r >= RESET_HOLD)
		else $error("hold applied before full hold");
	a_hold_release: assert property (pairOff8 ##1 pairOff8 |-> !tachoHoldA && !tachoHoldB)
		else $error("hold kept after keys released");
	a_clear_not_hold: assert property (|panelClear |-> !(tachoHoldA || tachoHoldB))
		else $error("clear and hold together");
	a_pair_no_edit: assert property (pairOn8 |-> !digitIncPulse[5] && !digitDecPulse[5])
		else $error("digit edit while reset pair held");
endmodule : panel_key_checker

bind panel_key_reset_control panel_key_checker #(
	.RESET_HOLD(RESET_HOLD),
	.MODE_HOLD (MODE_HOLD)
) chk (
	.mclk           (mclk),
	.rst            (rst),
	.keyIncPin      (keyIncPin),
	.keyDecPin      (keyDecPin),
	.regRdStb       (regRdStb),
	.regRdData      (regRdData),
	.digitIncPulse  (digitIncPulse),
	.digitDecPulse  (digitDecPulse),
	.setupEnterPulse(setupEnterPulse),
	.panelClear     (panelClear),
	.tachoHoldA     (tachoHoldA),
	.tachoHoldB     (tachoHoldB)
);

// ==== panel_operator_model.sv ====
// operator on the keypad: commanded key levels reach the pins with contact bounce
// assumes the bench changes cmdKeys right after a rising clock edge
module panel_operator_model (
	input  wire logic        mclk,
	input  wire logic [11:0] cmdKeys,
	output logic      [5:0]  keyIncPin,
	output logic      [5:0]  keyDecPin
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [11:0] now_r    = '0;
	logic [11:0] old_r    = '0;
	int          bounce_r = 0;
	initial {keyDecPin, keyIncPin} = '0;
	// three cycles of chatter between old and new level on every change
	always @(posedge mclk) begin
		if (cmdKeys !== now_r) begin
			old_r <= now_r;
			now_r <= cmdKeys;
			bounce_r <= 3;
		end else if (bounce_r > 0) begin
			bounce_r <= bounce_r - 1;
		end
		{keyDecPin, keyIncPin} <= bounce_r[0] ? old_r : now_r;
	end
endmodule : panel_operator_model

// ==== testbench.sv ====
// self-checking bench for the panel key and reset control
// assumes shortened hold, debounce and blink counts set below
module testbench
	import panel_key_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic                mclk = 0, rst = 1, resetInputPin = 0, counterHoldShown = 0;
	logic                regWrStb = 0, regRdStb = 0, rdPend = 0;
	logic [ADDR_W-1:0]   regAddr = '0;
	logic [DATA_W-1:0]   regWrData = '0, regRdData;
	logic [VALUE_W-1:0]  valueNow = '0, valueRef = '0;
	logic [NUM_KEYS-1:0] settableKeys = '0, cmdKeys = '0, keyLeds;
	logic [5:0]          keyIncPin, keyDecPin, digitIncPulse, digitDecPulse;
	logic                resetLamp, holdLamp, totalLamp, batchLamp, setupEnterPulse;
	logic                tachoHoldA, tachoHoldB;
	clear_type           panelClear;
	logic [15:0]         expQ[$];
	int                  error_cnt = 0, n_compared = 0, seed = 29;
	logic [15:0] cfgTab[8] = '{16'h0, 16'h1, 16'h21, 16'h2, 16'h22, 16'h3, 16'h4, 16'h24};
	logic [6:0]  clrTab[8] = '{7'h43, 7'h43, 7'h53, 7'h41, 7'h4b, 7'h67, 7'h42, 7'h21};
	logic [15:0] tacTab[3] = '{16'h5, 16'h45, 16'h65};
	logic [1:0]  holdTab[3] = '{2'h3, 2'h2, 2'h1};

	initial forever #25 mclk = ~mclk;

	panel_operator_model op (.mclk(mclk), .cmdKeys(cmdKeys), .keyIncPin(keyIncPin),
		.keyDecPin(keyDecPin));
	panel_key_reset_control #(.RESET_HOLD(40), .MODE_HOLD(80), .DEBOUNCE(4), .BLINK_HALF(4)) DUT (
		.mclk(mclk), .rst(rst), .keyIncPin(keyIncPin), .keyDecPin(keyDecPin),
		.resetInputPin(resetInputPin), .regAddr(regAddr), .regWrData(regWrData),
		.regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
		.valueNow(valueNow), .valueRef(valueRef), .settableKeys(settableKeys),
		.counterHoldShown(counterHoldShown), .keyLeds(keyLeds), .resetLamp(resetLamp),
		.holdLamp(holdLamp), .totalLamp(totalLamp), .batchLamp(batchLamp),
		.digitIncPulse(digitIncPulse), .digitDecPulse(digitDecPulse),
		.setupEnterPulse(setupEnterPulse), .panelClear(panelClear),
		.tachoHoldA(tachoHoldA), .tachoHoldB(tachoHoldB));

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic take(input logic [15:0] v);
		check(v, expQ.size() > 0 ? expQ.pop_front() : 16'hxxxx);
	endtask : take

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge mclk);
		regAddr <= a;
		regWrData <= d;
		regWrStb <= 1'b1;
		@(posedge mclk);
		regWrStb <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge mclk);
		regAddr <= a;
		regRdStb <= 1'b1;
		expQ.push_back(e);
		@(posedge mclk);
		regRdStb <= 1'b0;
	endtask : rd

	// blink > 0 expects blinking segments, else the lone pressed key lit
	task automatic press(input logic [11:0] keys, input int hold, input logic [11:0] blink);
		logic [11:0] orV, andV;
		orV = '0;
		andV = '1;
		@(posedge mclk);
		cmdKeys <= keys;
		repeat (14) @(posedge mclk);
		repeat (10) begin
			@(negedge mclk);
			orV |= keyLeds;
			andV &= keyLeds;
		end
		if (blink != 0) begin
			check(orV, blink);
			check(andV, '0);
		end else check(keyLeds, keys);
		repeat (hold - 24) @(posedge mclk);
	endtask : press

	task automatic rel;
		@(posedge mclk);
		cmdKeys <= '0;
		repeat (30) @(posedge mclk);
	endtask : rel

	task report_and_stop;
		if (error_cnt == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : report_and_stop

	always @(posedge mclk) rdPend <= regRdStb;
	always @(negedge mclk) begin
		if (!rst) begin
			if (rdPend) take(regRdData);
			if (|panelClear) take(16'h1000 | panelClear);
			if (setupEnterPulse) take(16'h2000);
			if (|{digitDecPulse, digitIncPulse}) take({4'h3, digitDecPulse, digitIncPulse});
		end
	end

	initial begin
		repeat (20000) @(posedge mclk);
		error_cnt++;
		report_and_stop;
	end

	initial begin
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		rd(REG_CTRL, CTRL_RESET);
		rd(4'hf, '0);
		// even reference so that half of it fills exactly six segments
		valueRef <= (VALUE_W'($random(seed)) | 20'h80000) & 20'hffffe;
		wr(REG_CTRL, 16'h0010);
		repeat (3) @(posedge mclk);
		check(keyLeds, 16'hfff);
		wr(REG_CTRL, 16'h0008);
		repeat (3) @(posedge mclk);
		check(keyLeds, '0);
		wr(REG_CTRL, 16'h0000);
		repeat (3) @(posedge mclk);
		check(keyLeds, '0);
		valueNow <= valueRef >> 1;
		repeat (3) @(posedge mclk);
		check(keyLeds, 16'h003f);
		valueNow <= valueRef;
		repeat (3) @(posedge mclk);
		check(keyLeds, 16'hfff);
		for (int i = 0; i < 12; i++) begin
			expQ.push_back(16'h3000 | (16'h1 << i));
			press(12'h1 << i, 25, '0);
			rel();
		end
		press(12'h820, 25, 12'hfff);
		rel();
		counterHoldShown <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			wr(REG_CTRL, cfgTab[i]);
			expQ.push_back(16'h1000 | clrTab[i]);
			press(12'h820, 60, 12'hfff);
			check(resetLamp, 1);
			check(holdLamp, 1);
			check(totalLamp, i == 2);
			check(batchLamp, i == 4);
			rel();
		end
		resetInputPin <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			wr(REG_CTRL, tacTab[i]);
			press(12'h820, 60, 12'hfff);
			check({tachoHoldA, tachoHoldB}, holdTab[i]);
			check({resetLamp, holdLamp}, '0);
			rel();
		end
		wr(REG_CTRL, 16'h0085);
		repeat (3) @(posedge mclk);
		check(keyLeds, 16'hfff);
		wr(REG_CTRL, 16'h0005);
		repeat (3) @(posedge mclk);
		check(keyLeds, 16'h0000);
		wr(REG_CTRL, 16'h0000);
		repeat (3) @(posedge mclk);
		check(resetLamp, 1);
		resetInputPin <= 1'b0;
		press(12'h005, 50, 12'h005);
		rel();
		settableKeys <= NUM_KEYS'($random(seed));
		expQ.push_back(16'h2000);
		press(12'h140, 100, 12'h140);
		rel();
		check(keyLeds, settableKeys);
		rd(REG_STATUS, 16'h0003);
		wr(REG_STATUS, 16'h0001);
		rd(REG_STATUS, 16'h0002);
		repeat (4) @(posedge mclk);
		check(16'(expQ.size()), '0);
		report_and_stop;
	end
endmodule : testbench
